/* rtl/eeprom_defines.svh */
//------------------------------------------------------------
// Shared constants
//------------------------------------------------------------
// Summary of operation
// - SDA falling while SCL high is a start; every command begins with one.
// - SDA rising while SCL high is a stop; after reads it means standby.
// - Data changes only while SCL low; high-time changes are start or stop.
// - Sample data on SCL rising edge, change driven data on SCL falling edge.
// - Transfers are eight bits; device pulls SDA low on the ninth clock.
// - Address word: four type bits, three select bits, one direction bit.
// - Three select bits must equal the three strapped select pins.
// - Floating select pins read as low in the comparison; the logic compares the pins as synchronised, with no pull-down.
// - Direction bit one means read, zero means write.
// - Matching address is acknowledged; mismatch is not, device idles until start.
// - Byte write: two address bytes, one data byte, each acknowledged, then stop.
// - Stop after write starts a timed cycle; device ignores everything meanwhile.
// - The timed write cycle finishes within three milliseconds.
// - Page write: up to sixty-three more data bytes, each acknowledged, then stop.
// - A short page writes only the bytes actually sent.
// - Array is 512 pages of 64 bytes, fifteen-bit word address.
// - Write-protect high blocks all writes; low allows normal writes.
// - Standby after power-up and after stop once internal work is done.
// - Only the low six address bits advance; page end wraps to page start.
// - No acknowledge to an address word until the write cycle ends.
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH
`define EE_MCLK_MHZ 125
`define EE_WR_TIME_US 3000
`define EE_WR_CYCLES (`EE_WR_TIME_US * `EE_MCLK_MHZ)
`define EE_TIMER_BITS 20
`define EE_ADDR_BITS 15
`define EE_PAGE_BITS 6
`define EE_PAGE_BYTES 64
`define EE_ACK_CNT 4'h8
`define EE_LAST_BIT 4'h7
`define EE_FIFO_DEPTH 16
`define EE_FIFO_WIDTH 14
`define EE_SEL_RESET 3'h0
`endif

/* rtl/eeprom_pkg.sv */
package eeprom_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEVADDR = 3'h1,
        ST_ADDRHI = 3'h3,
        ST_ADDRLO = 3'h2,
        ST_DATA = 3'h6,
        ST_WRITING = 3'h7,
        ST_IGNORE = 3'h5
    } link_state_t;

    typedef struct packed {
        logic [2:0] sclS;
        logic [2:0] sdaS;
        logic [2:0] wpS;
        logic [2:0] sel1;
        logic [2:0] sel2;
        logic [2:0] sel3;
        logic sclF;
        logic sdaF;
        logic wpF;
        logic [2:0] selF;
        link_state_t state;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [14:0] addr;
        logic ackPend;
        logic oe;
        logic gotData;
        logic [63:0] mask;
        logic [19:0] timer;
        logic [6:0] copyIdx;
        logic standby;
        logic busy;
    } slave_state_t;
endpackage : eeprom_pkg

/* rtl/eeprom_slave_write.sv */
`timescale 1ns/1ps
`include "eeprom_defines.svh"

//------------------------------------------------------------
// Byte FIFO between the serial receiver and the page buffer
//------------------------------------------------------------
module byte_fifo #(
    parameter int Width = `EE_FIFO_WIDTH,
    parameter int Depth = `EE_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Filling side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [Width-1:0] inData,
    // Draining side.
    output logic outValid,
    input wire logic outReady,
    output logic [Width-1:0] outData
);
    localparam int PtrBits = $clog2(Depth);

    typedef struct packed {
        logic [PtrBits-1:0] wr;
        logic [PtrBits-1:0] rd;
        logic [PtrBits:0] count;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t d;
    logic [Width-1:0] store [Depth];
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign inReady = (q.count != (PtrBits+1)'(Depth));
    assign outValid = (q.count != '0);
    assign outData = store[q.rd];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointer and count update.
    always_comb begin
        d = q;
        if (push) begin
            d.wr = q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = q.rd + 1'b1;
        end
        if (push && !pop) begin
            d.count = q.count + 1'b1;
        end else if (pop && !push) begin
            d.count = q.count - 1'b1;
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Storage has no reset; only written slots are ever read.
    always_ff @(posedge mclk) begin
        if (push) begin
            store[q.wr] <= inData;
        end
    end
endmodule : byte_fifo

//------------------------------------------------------------
// Write-side target logic of the serial EEPROM
//------------------------------------------------------------
module eeprom_slave_write
    import eeprom_pkg::*;
#(
    // Device type prefix; this value is arbitrary.
    parameter logic [3:0] DeviceType = 4'h5,
    parameter int unsigned WriteCycles = `EE_WR_CYCLES
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Two-wire bus pins.
    input wire logic sclPin,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Straps and protection.
    input wire logic [2:0] deviceSelectPins,
    input wire logic writeProtect,
    // Status.
    output logic standby,
    output logic writeBusy
);
    slave_state_t q;
    slave_state_t d;
    logic [7:0] pageBuf [`EE_PAGE_BYTES];
    logic [7:0] mem [2**`EE_ADDR_BITS];
    logic sclNew;
    logic sdaNew;
    logic sclRise;
    logic sclFall;
    logic startEvt;
    logic stopEvt;
    logic [7:0] rxByte;
    logic byteDone;
    logic fifoInValid;
    logic fifoInReady;
    logic fifoOutValid;
    logic drainReady;
    logic [13:0] fifoOut;
    logic copyWr;
    logic [5:0] copyOff;

    // A change counts only once the last two sync stages agree.
    function automatic logic agreed(input logic [2:0] s, input logic old);
        return (s[1] == s[2]) ? s[2] : old;
    endfunction : agreed

    assign sclNew = agreed(q.sclS, q.sclF);
    assign sdaNew = agreed(q.sdaS, q.sdaF);
    assign sclRise = sclNew && !q.sclF;
    assign sclFall = !sclNew && q.sclF;
    // SDA edges with SCL steady high are bus conditions.
    assign startEvt = q.sclF && sclNew && q.sdaF && !sdaNew;
    assign stopEvt = q.sclF && sclNew && !q.sdaF && sdaNew;
    // The bit is the filtered level seen together with the filtered rise. An acknowledge
    // released in that same cycle then cannot turn the next bit into a zero.
    assign rxByte = {q.shift[6:0], sdaNew};
    assign byteDone = sclRise && (q.bitCnt == `EE_LAST_BIT);
    assign fifoInValid = byteDone && (q.state == ST_DATA);
    // The copy owns the page buffer, so draining stalls while it runs.
    assign drainReady = !(q.state == ST_WRITING && q.copyIdx != '0);
    assign copyWr = (q.state == ST_WRITING) && !fifoOutValid && !q.copyIdx[6]
        && q.mask[q.copyIdx[5:0]];
    assign copyOff = q.copyIdx[5:0];

    byte_fifo #(
        .Width(`EE_FIFO_WIDTH),
        .Depth(`EE_FIFO_DEPTH)
    ) rxFifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData({q.addr[5:0], rxByte}),
        .outValid(fifoOutValid),
        .outReady(drainReady),
        .outData(fifoOut)
    );

    //------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------
    always_comb begin
        d = q;
        // Three-stage synchronisers; the first stage feeds only the second.
        d.sclS = {q.sclS[1:0], sclPin};
        d.sdaS = {q.sdaS[1:0], sdaIn};
        d.wpS = {q.wpS[1:0], writeProtect};
        d.sel1 = deviceSelectPins;
        d.sel2 = q.sel1;
        d.sel3 = q.sel2;
        d.sclF = sclNew;
        d.sdaF = sdaNew;
        d.wpF = agreed(q.wpS, q.wpF);
        d.selF = (q.sel2 == q.sel3) ? q.sel3 : q.selF;
        // Drained bytes land in the page buffer and mark their slot.
        if (fifoOutValid && drainReady) begin
            d.mask[fifoOut[13:8]] = 1'b1;
        end
        if (q.state == ST_WRITING) begin
            // Inputs are ignored for the whole timed cycle.
            d.timer = q.timer + 1'b1;
            if (!fifoOutValid && !q.copyIdx[6]) begin
                d.copyIdx = q.copyIdx + 1'b1;
            end
            if (q.timer == `EE_TIMER_BITS'(WriteCycles - 1)) begin
                d.state = ST_IDLE;
            end
        end else if (startEvt) begin
            d.state = ST_DEVADDR;
            d.bitCnt = '0;
            d.ackPend = 1'b0;
            d.oe = 1'b0;
        end else if (stopEvt) begin
            d.oe = 1'b0;
            d.ackPend = 1'b0;
            if (q.state == ST_DATA && q.gotData && !q.wpF) begin
                d.state = ST_WRITING;
                d.timer = '0;
                d.copyIdx = '0;
            end else begin
                d.state = ST_IDLE;
            end
        end else if (q.state != ST_IDLE && q.state != ST_IGNORE) begin
            if (sclRise) begin
                if (q.bitCnt == `EE_ACK_CNT) begin
                    d.bitCnt = '0;
                end else begin
                    d.bitCnt = q.bitCnt + 1'b1;
                    d.shift = rxByte;
                end
            end
            if (byteDone) begin
                unique case (q.state)
                    ST_DEVADDR: begin
                        // Prefix and straps must both match.
                        if (rxByte[7:4] == DeviceType && rxByte[3:1] == q.selF) begin
                            d.ackPend = 1'b1;
                            d.state = rxByte[0] ? ST_IGNORE : ST_ADDRHI;
                        end else begin
                            d.state = ST_IGNORE;
                        end
                    end
                    ST_ADDRHI: begin
                        d.addr[14:8] = rxByte[6:0];
                        d.ackPend = 1'b1;
                        d.state = ST_ADDRLO;
                    end
                    ST_ADDRLO: begin
                        d.addr[7:0] = rxByte;
                        d.ackPend = 1'b1;
                        d.state = ST_DATA;
                        d.gotData = 1'b0;
                        d.mask = '0;
                    end
                    ST_DATA: begin
                        // A full queue withholds the acknowledge.
                        if (fifoInReady) begin
                            d.ackPend = 1'b1;
                            d.gotData = 1'b1;
                            d.addr[5:0] = q.addr[5:0] + 1'b1;
                        end
                    end
                    default: begin
                        d.state = ST_IDLE;
                    end
                endcase
            end
            // Drive and release happen on falling edges only.
            if (sclFall && q.ackPend && q.bitCnt == `EE_ACK_CNT) begin
                d.oe = 1'b1;
                d.ackPend = 1'b0;
            end else if (sclFall && q.oe && q.bitCnt == '0) begin
                d.oe = 1'b0;
            end
        end
        // A refused address releases the line at the next falling edge.
        if (q.state == ST_IGNORE && sclFall) begin
            d.oe = 1'b0;
            d.ackPend = 1'b0;
        end
        if (q.state == ST_IGNORE && q.ackPend && sclFall) begin
            d.oe = 1'b1;
        end
        d.standby = (d.state == ST_IDLE);
        d.busy = (d.state == ST_WRITING);
    end

    //------------------------------------------------------------
    // Registers and storage
    //------------------------------------------------------------
    // State register; straps are caught by the clocked path after release.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.sclS <= 3'h7;
            q.sdaS <= 3'h7;
            q.sclF <= 1'b1;
            q.sdaF <= 1'b1;
            q.selF <= `EE_SEL_RESET;
            q.state <= ST_IDLE;
            q.standby <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Page buffer fill and array commit.
    always_ff @(posedge mclk) begin
        if (fifoOutValid && drainReady) begin
            pageBuf[fifoOut[13:8]] <= fifoOut[7:0];
        end
        if (copyWr) begin
            mem[{q.addr[14:6], copyOff}] <= pageBuf[copyOff];
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = q.oe;
    assign standby = q.standby;
    assign writeBusy = q.busy;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    start_detect_a: assert property (
        startEvt && q.state != ST_WRITING |=> q.state == ST_DEVADDR && !q.oe)
        else $error("start not taken");
    stop_idle_a: assert property (
        stopEvt && q.state != ST_WRITING && q.state != ST_DATA |=> q.state == ST_IDLE)
        else $error("stop not taken");
    drive_on_fall_a: assert property (
        $rose(q.oe) |-> $past(sclFall))
        else $error("ack driven off a falling edge");
    ack_ninth_a: assert property (
        $rose(q.oe) |-> q.bitCnt == `EE_ACK_CNT && !q.sclF)
        else $error("ack outside ninth clock");
    mismatch_nack_a: assert property (
        byteDone && q.state == ST_DEVADDR && rxByte[3:1] != q.selF
        |=> q.state == ST_IGNORE && !q.ackPend)
        else $error("mismatched address acknowledged");
    busy_silent_a: assert property (
        q.state == ST_WRITING |-> !q.oe && !q.ackPend)
        else $error("answer during write cycle");
    protect_block_a: assert property (
        stopEvt && q.state == ST_DATA && q.wpF |=> q.state == ST_IDLE)
        else $error("protected write started");
    page_wrap_a: assert property (
        byteDone && q.state == ST_DATA && fifoInReady
        |=> q.addr[14:6] == $past(q.addr[14:6])
        && q.addr[5:0] == $past(q.addr[5:0]) + 6'h01)
        else $error("page address step wrong");
    write_time_a: assert property (
        q.state == ST_WRITING |-> q.timer < `EE_TIMER_BITS'(WriteCycles))
        else $error("write cycle overran");
    select_ack_a: assert property (
        byteDone && q.state == ST_DEVADDR && rxByte[7:4] == DeviceType
        && rxByte[3:1] == q.selF |=> q.ackPend)
        else $error("matching address refused");
    sample_rise_a: assert property (
        sclRise && q.bitCnt != `EE_ACK_CNT
        && q.state inside {ST_DEVADDR, ST_ADDRHI, ST_ADDRLO, ST_DATA}
        |=> q.shift[0] == $past(sdaNew))
        else $error("bit not taken at rising clock");
endmodule : eeprom_slave_write

/* sim/i2c_ctrl_model.sv */
`timescale 1ns/1ps

//------------------------------------------------------------
// Bus controller model for the two-wire link
//------------------------------------------------------------
module i2c_ctrl_model (
    // Clock.
    input wire logic mclk,
    // Bus wires.
    input wire logic sdaWire,
    output logic sclOut,
    output logic sdaLow
);
    // The clock stands high and data is released to the pull-up outside frames.
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end

    // Every pin change lands just after a rising edge of mclk.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // Release data first, so that a repeated start also works mid-frame.
    task automatic busStart();
        tick(1);
        sdaLow <= 1'b0;
        tick(3);
        sclOut <= 1'b1;
        tick(4);
        sdaLow <= 1'b1;
        tick(4);
        sclOut <= 1'b0;
        tick(2);
    endtask : busStart

    // Data moves only in the low phase; each phase lasts four mclk cycles.
    task automatic sendBit(input logic b);
        sdaLow <= !b;
        tick(2);
        sclOut <= 1'b1;
        tick(4);
        sclOut <= 1'b0;
        tick(2);
    endtask : sendBit

    // Eight bits MSB first, then a ninth clock with data released for the answer.
    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sendBit(b[i]);
        end
        sdaLow <= 1'b0;
        tick(2);
        sclOut <= 1'b1;
        tick(3);
        ack = (sdaWire === 1'b0);
        tick(1);
        sclOut <= 1'b0;
        tick(2);
    endtask : sendByte

    // Data rises while the clock is high; the bus is then left idle.
    task automatic busStop();
        sdaLow <= 1'b1;
        tick(2);
        sclOut <= 1'b1;
        tick(4);
        sdaLow <= 1'b0;
        tick(4);
    endtask : busStop

    // Nine released clocks flush a half-sent byte before a fresh start.
    task automatic recover();
        for (int i = 0; i < 9; i++) begin
            sendBit(1'b1);
        end
        busStart();
    endtask : recover
endmodule : i2c_ctrl_model

/* sim/eeprom_slave_write_tb.sv */
`timescale 1ns/1ps

//------------------------------------------------------------
// Self-checking bench for the write side
//------------------------------------------------------------
module eeprom_slave_write_tb;
    localparam int WriteCyc = 200;
    localparam logic [3:0] DevType = 4'h5;
    localparam logic [2:0] Strap = 3'h5;
    localparam logic [7:0] DevW = {DevType, Strap, 1'b0};
    localparam int Limit = 30000;

    logic mclk;
    logic rstN;
    logic sclPin;
    logic ctrlLow;
    logic sdaWire;
    logic sdaOut;
    logic sdaOe;
    logic [2:0] selPins;
    logic writeProtect;
    logic standby;
    logic writeBusy;
    int failCount;
    int checked;
    int cycles;

    // Open-drain wire: low when either side pulls, otherwise the pull-up wins.
    assign sdaWire = !(sdaOe || ctrlLow);

    eeprom_slave_write #(.DeviceType(DevType), .WriteCycles(WriteCyc)) dut (
        .mclk(mclk), .rst_n(rstN), .sclPin(sclPin), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .deviceSelectPins(selPins),
        .writeProtect(writeProtect), .standby(standby), .writeBusy(writeBusy));

    i2c_ctrl_model ctrl (.mclk(mclk), .sdaWire(sdaWire), .sclOut(sclPin), .sdaLow(ctrlLow));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // A hang counts as a failure and still reaches the closing report.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == Limit) begin
            failCount = failCount + 1;
            test_done();
        end
    end

    task automatic check(input logic seen, input logic want);
        checked = checked + 1;
        if (seen !== want) begin
            failCount = failCount + 1;
            $display("MISMATCH at %0t: saw %b, wanted %b", $time, seen, want);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    // Address word, two address bytes, nData bytes, stop; every ack compared.
    task automatic frame(input logic [7:0] dev, input int nData, input logic want);
        logic ack;
        ctrl.busStart();
        ctrl.sendByte(dev, ack);
        check(ack, want);
        ctrl.sendByte(8'hC1, ack);
        check(ack, want);
        ctrl.sendByte(8'h3E, ack);
        check(ack, want);
        for (int i = 0; i < nData; i++) begin
            ctrl.sendByte(8'(8'hA0 + i), ack);
            check(ack, want);
        end
        ctrl.busStop();
    endtask : frame

    // Bounded wait for the timed cycle to end; the count is returned.
    task automatic waitIdle(output int n);
        n = 0;
        while (writeBusy === 1'b1 && n < WriteCyc + 50) begin
            ctrl.tick(1);
            n++;
        end
    endtask : waitIdle

    // The stop has just been seen; a cycle either runs for its full length or not at all.
    task automatic expectCycle(input logic want);
        int n;
        ctrl.tick(8);
        check(writeBusy, want);
        check(standby, !want);
        waitIdle(n);
        if (want)
            check(n >= WriteCyc - 20 && n <= WriteCyc, 1'b1);
        check(standby, 1'b1);
    endtask : expectCycle

    task automatic testByteWrite();
        frame(DevW, 1, 1'b1);
        expectCycle(1'b1);
        $display("byte write done");
    endtask : testByteWrite

    // Polling is refused while the cycle runs and answered once it ends.
    task automatic testPoll();
        logic ack;
        int n;
        frame(DevW, 1, 1'b1);
        ctrl.busStart();
        ctrl.sendByte(DevW, ack);
        check(ack, 1'b0);
        ctrl.busStop();
        waitIdle(n);
        ctrl.busStart();
        ctrl.sendByte(DevW, ack);
        check(ack, 1'b1);
        ctrl.busStop();
        expectCycle(1'b0);
        $display("ack polling done");
    endtask : testPoll

    // Only the strapped select value and the right type prefix get an answer.
    task automatic testSelect();
        logic ack;
        for (int s = 0; s < 9; s++) begin
            ctrl.busStart();
            if (s < 8)
                ctrl.sendByte({DevType, 3'(s), 1'b0}, ack);
            else
                ctrl.sendByte({~DevType, Strap, 1'b0}, ack);
            check(ack, s == int'(Strap));
            ctrl.busStop();
        end
        expectCycle(1'b0);
        $display("select done");
    endtask : testSelect

    task automatic testRead();
        logic ack;
        ctrl.busStart();
        ctrl.sendByte({DevType, Strap, 1'b1}, ack);
        check(ack, 1'b1);
        ctrl.busStop();
        expectCycle(1'b0);
        $display("read bit done");
    endtask : testRead

    // Protected bytes are still answered, but no cycle follows the stop.
    task automatic testProtect();
        @(posedge mclk) writeProtect <= 1'b1;
        ctrl.tick(4);
        frame(DevW, 2, 1'b1);
        expectCycle(1'b0);
        @(posedge mclk) writeProtect <= 1'b0;
        ctrl.tick(4);
        $display("protect done");
    endtask : testProtect

    // More than a page: the slot counter wraps and every byte is still answered.
    task automatic testPage();
        frame(DevW, 66, 1'b1);
        expectCycle(1'b1);
        $display("page write done");
    endtask : testPage

    // A frame cut off mid-byte is flushed, then a normal write must succeed.
    task automatic testAbort();
        logic ack;
        int n;
        ctrl.busStart();
        ctrl.sendByte(DevW, ack);
        ctrl.sendByte(8'h00, ack);
        ctrl.sendByte(8'h10, ack);
        for (int i = 0; i < 4; i++) begin
            ctrl.sendBit(1'b1);
        end
        ctrl.recover();
        ctrl.busStop();
        ctrl.tick(8);
        waitIdle(n);
        frame(DevW, 1, 1'b1);
        expectCycle(1'b1);
        $display("recovery done");
    endtask : testAbort

    // Every strap setting answers its own select value and refuses the one with bit 0 flipped; zero stands for open pins.
    task automatic testStraps();
        logic ack;
        for (int p = 0; p < 8; p++) begin
            @(posedge mclk) selPins <= 3'(p);
            ctrl.tick(8);
            ctrl.busStart();
            ctrl.sendByte({DevType, 3'(p), 1'b0}, ack);
            check(ack, 1'b1);
            ctrl.busStop();
            ctrl.busStart();
            ctrl.sendByte({DevType, 3'(p ^ 1), 1'b0}, ack);
            check(ack, 1'b0);
            ctrl.busStop();
        end
        @(posedge mclk) selPins <= Strap;
        ctrl.tick(8);
        $display("strap sweep done");
    endtask : testStraps

    // A reset in the middle of a timed cycle drops it, and the device answers again.
    task automatic testReset();
        logic ack;
        frame(DevW, 1, 1'b1);
        ctrl.tick(8);
        check(writeBusy, 1'b1);
        @(posedge mclk) rstN <= 1'b0;
        ctrl.tick(2);
        check(writeBusy, 1'b0);
        check(standby, 1'b1);
        check(sdaOe, 1'b0);
        @(posedge mclk) rstN <= 1'b1;
        ctrl.tick(10);
        ctrl.busStart();
        ctrl.sendByte(DevW, ack);
        check(ack, 1'b1);
        ctrl.busStop();
        $display("reset recovery done");
    endtask : testReset

    initial begin
        failCount = 0;
        checked = 0;
        cycles = 0;
        rstN = 1'b0;
        selPins = Strap;
        writeProtect = 1'b0;
        repeat (12) @(posedge mclk);
        check(sdaOe, 1'b0);
        check(standby, 1'b1);
        check(writeBusy, 1'b0);
        check(sdaOut, 1'b0);
        rstN <= 1'b1;
        ctrl.tick(10);
        $display("reset done");
        testByteWrite();
        testPoll();
        testSelect();
        testStraps();
        testRead();
        testProtect();
        testPage();
        testAbort();
        testReset();
        test_done();
    end
endmodule : eeprom_slave_write_tb
